/* File: rtl/mmio_pkg.sv */
// package: register map, mode codes and carriers for the multipurpose pin bank
package mmio_pkg;
    localparam int unsigned MMIO_NPINS = 6;              // number of pins
    localparam logic [7:0] MMIO_OFS_OUT   = 8'h1A;      // pin_output_levels
    localparam logic [7:0] MMIO_OFS_IN    = 8'h1B;      // pin_input_levels
    localparam logic [7:0] MMIO_OFS_MODEL = 8'h1C;      // pin_mode_cfg_low
    localparam logic [7:0] MMIO_OFS_MODEM = 8'h1D;      // pin_mode_cfg_mid
    localparam logic [7:0] MMIO_OFS_MODEH = 8'h1E;      // pin_mode_cfg_high
    localparam logic [7:0] MMIO_OFS_PDN   = 8'h4E;      // discharge pulldown control
    localparam logic [7:0] MMIO_RST_BYTE  = 8'h00;      // reset value of data registers
    localparam logic [7:0] MMIO_MODEH_MASK = 8'h03;     // writable bits of high mode register
    localparam logic [7:0] MMIO_PDN_MASK   = 8'hF0;     // writable bits of pulldown register
    localparam logic [7:0] MMIO_DATA_MASK  = 8'h3F;     // used bits of data registers
    localparam int unsigned MMIO_PDN_LSB = 4;           // pulldown enables start here

    // 3-bit pin mode codes
    localparam logic [2:0] MMIO_M_SENSE = 3'h0;         // tracking sense / margin disable
    localparam logic [2:0] MMIO_M_PPIO  = 3'h1;         // push-pull logic i/o
    localparam logic [2:0] MMIO_M_ODIO  = 3'h2;         // open-drain logic i/o
    localparam logic [2:0] MMIO_M_PPFLT = 3'h3;         // push-pull fault output
    localparam logic [2:0] MMIO_M_ODFLT = 3'h4;         // open-drain fault output
    localparam logic [2:0] MMIO_M_LIN   = 3'h5;         // logic input only
    localparam logic [2:0] MMIO_M_WDOG  = 3'h6;         // pin 6 watchdog expire output
    localparam logic [2:0] MMIO_M_SPEC  = 3'h7;         // special function per pin

    // register access carrier
    typedef struct packed {
        logic       wrEn;                                // write strobe
        logic       rdEn;                                // read strobe
        logic [7:0] addr;                                // register offset
        logic [7:0] wdata;                               // write data
    } mmio_req_t;

    // fault and function inputs from the rest of the device
    typedef struct packed {
        logic       anyFault;                            // combined fault, high = fault
        logic [11:0] monFault;                           // per monitored input fault, high = crossed
        logic [11:0] selA;                               // selectable_fault_a dependencies
        logic [11:0] selB;                               // selectable_fault_b dependencies
        logic       watchdogExpire;                      // watchdog output level, high = expired
        logic       seqFault;                            // sequencing fault, high = fault
    } mmio_fault_t;

    // decoded pin functions handed back to the device
    typedef struct packed {
        logic [3:0] senseIn;                             // tracking sense levels pins 1..4
        logic [3:0] senseValid;                          // pin in sense mode
        logic       marginDisable;                       // pin 6 margin disable input
        logic       marginRaise;                         // margin_raise_input
        logic       marginLower;                         // margin_lower_input
        logic       manualReset;                         // manual_reset_input
        logic       watchdogKick;                        // watchdog_kick_input
    } mmio_func_t;
endpackage

/* File: rtl/mmio_pin_bank.sv */
// module: six multipurpose pins, their mode registers and data registers
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - pins 1-3 modes in first/second registers
// - pins 4-6 modes in second/third registers
// - code 000 sense inputs, pin6 margin disable
// - codes 001/010/101 push-pull, open-drain, input
// - codes 011/100 fault outputs per pin
// - combined fault output drives active low
// - code 111 margin, reset, watchdog, power-up fault
// - code 110 pin 6 watchdog output
// - output register bit n-1 sets pin n
// - input register read-only, shows pin levels
// - data registers cleared, not boot-loaded
// - upper nibble enables sense discharge pulldowns
// - tracking sense levels passed to tracker
// - ramp and threshold settings live outside
// - selectable fault asserts on any selected input
module mmio_pin_bank
    import mmio_pkg::*;
#(
    parameter int unsigned NPINS = MMIO_NPINS              // pin count
) (
    input  wire logic         clk,                         // 50 MHz clock
    input  wire logic         rst_n,                       // async reset, active low
    input  wire logic         clkEn,                       // freezes all state when low
    input  wire mmio_req_t    regReq,                      // register access request
    output logic [7:0]        regRdata,                    // read data
    output logic              regRvalid,                   // read data valid pulse
    input  wire mmio_fault_t  faultIn,                     // fault sources
    input  wire logic [NPINS-1:0] pinIn,                   // pin levels from pads
    output logic [NPINS-1:0]  pinOut,                      // pin output level
    output logic [NPINS-1:0]  pinOe,                       // pin output enable, high drives
    output logic [3:0]        senseDischarge,              // sense pulldown enables
    output mmio_func_t        funcOut                      // decoded pin functions
);
    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    // the pin-to-function map is fixed to six pins,
    // so any other count is refused at build time
    if (NPINS != MMIO_NPINS) begin : g_chk
        $error("pin bank is built for six pins only");
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    // register map, one byte each:
    //   0x1A output levels, bit n-1 drives pin n
    //   0x1B input levels, read only
    //   0x1C to 0x1E three-bit mode per pin, packed
    //   0x4E discharge enables in the upper nibble
    //   other offsets read zero and ignore writes
    logic [7:0]       outLvl_r;                            // pin_output_levels
    logic [7:0]       modeLow_r;                           // pin_mode_cfg_low
    logic [7:0]       modeMid_r;                           // pin_mode_cfg_mid
    logic [7:0]       modeHigh_r;                          // pin_mode_cfg_high
    logic [7:0]       pdn_r;                               // pulldown control
    logic [NPINS-1:0] sync1_r;                             // first synchroniser stage
    logic [NPINS-1:0] sync2_r;                             // second synchroniser stage
    logic [2:0]       mode [NPINS];                        // decoded mode per pin
    logic [NPINS-1:0] drvLvl;                              // fault level each pin would drive in a fault mode
    logic [NPINS-1:0] pinOut_nxt;                          // next pad level
    logic [NPINS-1:0] pinOe_nxt;                           // next pad enable
    logic             faultA;                              // selectable fault a, high = fault
    logic             faultB;                              // selectable fault b, high = fault

    // is this a write to the given offset
    // shared by every register write decode
    function automatic logic wrHit(input mmio_req_t r, input logic [7:0] ofs);
        return r.wrEn && (r.addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // mode field unpacking
    // pins 3 and 6 straddle two registers, so the
    // host writes both bytes; in between such a pin
    // briefly runs a mixed code
    always_comb begin
        mode[0] = modeLow_r[2:0];
        mode[1] = modeLow_r[5:3];
        mode[2] = {modeMid_r[0], modeLow_r[7:6]};
        mode[3] = modeMid_r[3:1];
        mode[4] = modeMid_r[6:4];
        mode[5] = {modeHigh_r[1:0], modeMid_r[7]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration register writes
    // reserved upper bits of the high register are
    // dropped on the way in and always read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // all pins wake undriven in code 000: sense inputs on pins 1 to 4, margin disable on pin 6
            modeLow_r  <= MMIO_RST_BYTE;
            modeMid_r  <= MMIO_RST_BYTE;
            modeHigh_r <= MMIO_RST_BYTE;
        end else if (clkEn) begin
            // reserved codes are kept as written; host must avoid them
            if (wrHit(regReq, MMIO_OFS_MODEL)) begin
                modeLow_r <= regReq.wdata;
            end
            if (wrHit(regReq, MMIO_OFS_MODEM)) begin
                modeMid_r <= regReq.wdata;
            end
            if (wrHit(regReq, MMIO_OFS_MODEH)) begin
                modeHigh_r <= regReq.wdata & MMIO_MODEH_MASK;
            end
        end
    end

    // output data and pulldown writes
    // unused bits are masked off so that reads
    // return zero there
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // never boot-loaded: always comes up clear
            outLvl_r <= MMIO_RST_BYTE;
            pdn_r    <= MMIO_RST_BYTE;
        end else if (clkEn) begin
            if (wrHit(regReq, MMIO_OFS_OUT)) begin
                outLvl_r <= regReq.wdata & MMIO_DATA_MASK;
            end
            if (wrHit(regReq, MMIO_OFS_PDN)) begin
                pdn_r <= regReq.wdata & MMIO_PDN_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin input synchroniser
    // pads are asynchronous to clk; only the second
    // stage feeds logic, the first may be metastable,
    // so reads lag the pad by two clock edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else if (clkEn) begin
            sync1_r <= pinIn;
            sync2_r <= sync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register reads, one cycle latency; input register ignores writes
    // read data holds until the next read; valid
    // pulses for a single cycle per request;
    // a write to the input register matches no
    // write decode and so changes nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata  <= MMIO_RST_BYTE;
            regRvalid <= 1'b0;
        end else if (clkEn) begin
            regRvalid <= regReq.rdEn;
            if (regReq.rdEn) begin
                unique case (regReq.addr)
                    MMIO_OFS_OUT:   regRdata <= outLvl_r;
                    MMIO_OFS_IN:    regRdata <= {2'h0, sync2_r};
                    MMIO_OFS_MODEL: regRdata <= modeLow_r;
                    MMIO_OFS_MODEM: regRdata <= modeMid_r;
                    MMIO_OFS_MODEH: regRdata <= modeHigh_r;
                    MMIO_OFS_PDN:   regRdata <= pdn_r;
                    default:        regRdata <= MMIO_RST_BYTE; // unmapped reads zero
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // selectable faults: any selected monitored input crossing
    // dependency masks and polarity live outside;
    // here the selected crossings are only merged
    always_comb begin
        faultA = |(faultIn.monFault & faultIn.selA);
        faultB = |(faultIn.monFault & faultIn.selB);
    end

    ////////////////////////////////////////////////////////////////////////////
    // output drive per pin and mode
    // one case on each pin's mode builds its drive;
    // a released open-drain pin is left to the board
    // pull-up, so pinOut stays low while it floats
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            // fault source per pin, driven active low
            if (i < 4) begin
                drvLvl[i] = ~faultIn.anyFault;
            end else if (i == 4) begin
                drvLvl[i] = ~faultA;
            end else begin
                drvLvl[i] = ~faultB;
            end
            pinOut_nxt[i] = 1'b0;
            pinOe_nxt[i]  = 1'b0;
            unique case (mode[i])
                MMIO_M_PPIO: begin
                    pinOut_nxt[i] = outLvl_r[i];
                    pinOe_nxt[i]  = 1'b1;
                end
                MMIO_M_ODIO: begin
                    pinOe_nxt[i] = ~outLvl_r[i];
                end
                MMIO_M_PPFLT: begin
                    pinOut_nxt[i] = drvLvl[i];
                    pinOe_nxt[i]  = 1'b1;
                end
                MMIO_M_ODFLT: begin
                    pinOe_nxt[i] = ~drvLvl[i];
                end
                MMIO_M_WDOG: begin
                    // reserved on pins 1 to 5: left released
                    pinOe_nxt[i] = (i == 5) && faultIn.watchdogExpire;
                end
                MMIO_M_SPEC: begin
                    // an input on pins 2 to 5, reserved on pin 1
                    pinOe_nxt[i] = (i == 5) && faultIn.seqFault;
                end
                default: begin                             // sense and input modes float
                    pinOe_nxt[i] = 1'b0;
                end
            endcase
        end
    end

    // registered pad drive
    // registered so decode glitches never reach a pad
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinOut <= '0;
            pinOe  <= '0;
        end else if (clkEn) begin
            pinOut <= pinOut_nxt;
            pinOe  <= pinOe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoded input functions, taken from synchronised levels
    // a pin outside its function mode reports 0;
    // sense levels go out unconditionally
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            funcOut        <= '0;
            senseDischarge <= '0;
        end else if (clkEn) begin
            senseDischarge <= pdn_r[MMIO_PDN_LSB +: 4];
            for (int i = 0; i < 4; i++) begin
                // tracker applies its own ramp slew and threshold
                funcOut.senseIn[i]    <= sync2_r[i];
                funcOut.senseValid[i] <= (mode[i] == MMIO_M_SENSE);
            end
            funcOut.marginDisable <= (mode[5] == MMIO_M_SENSE) && sync2_r[5];
            funcOut.marginRaise   <= (mode[1] == MMIO_M_SPEC) && sync2_r[1];
            funcOut.marginLower   <= (mode[2] == MMIO_M_SPEC) && sync2_r[2];
            funcOut.manualReset   <= (mode[3] == MMIO_M_SPEC) && sync2_r[3];
            funcOut.watchdogKick  <= (mode[4] == MMIO_M_SPEC) && sync2_r[4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    // every check runs on clk and rests during reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    pp_out_level_a: assert property (clkEn && mode[0] == MMIO_M_PPIO && $stable(mode[0]) |=>
        pinOe[0] && pinOut[0] == $past(outLvl_r[0]))
        else $error("push-pull pin 1 level wrong");
    od_low_only_a: assert property (clkEn && mode[1] == MMIO_M_ODIO |=> pinOe[1] == !$past(outLvl_r[1]))
        else $error("open-drain pin 2 enable wrong");
    anyflt_low_a: assert property (clkEn && mode[2] == MMIO_M_PPFLT && faultIn.anyFault |=> !pinOut[2] && pinOe[2])
        else $error("any-fault output not low");
    selflt_a: assert property (clkEn && mode[4] == MMIO_M_ODFLT && faultA |=> pinOe[4])
        else $error("selectable fault a not driven");
    in_sync_a: assert property (clkEn [*3] |-> sync2_r == $past(pinIn, 2))
        else $error("input synchroniser depth wrong");
    in_readonly_a: assert property (clkEn && regReq.wrEn && regReq.addr == MMIO_OFS_IN |=>
        $stable(outLvl_r) && $stable(modeLow_r))
        else $error("input register write had effect");
    rd_in_a: assert property (clkEn && regReq.rdEn && regReq.addr == MMIO_OFS_IN |=>
        regRvalid && regRdata == {2'h0, $past(sync2_r)})
        else $error("input register read wrong");
    wd_pin6_a: assert property (clkEn && mode[5] == MMIO_M_WDOG |=> pinOe[5] == $past(faultIn.watchdogExpire))
        else $error("watchdog output wrong");
    mode_high_a: assert property (modeHigh_r[7:2] == 6'h00)
        else $error("reserved mode bits set");
    sense_float_a: assert property (clkEn && mode[0] == MMIO_M_SENSE |=> !pinOe[0])
        else $error("sense pin driven");

    // pins that must float in their mode
    lin_float_a: assert property (clkEn && mode[2] == MMIO_M_LIN |=> !pinOe[2])
        else $error("input-only pin driven");
    rsv_float_a: assert property (clkEn && mode[4] == MMIO_M_SENSE |=> !pinOe[4])
        else $error("pin 5 driven in reserved code");
    spec_float_a: assert property (clkEn && mode[3] == MMIO_M_SPEC |=> !pinOe[3])
        else $error("manual reset pin driven");

    // fault outputs
    anyflt_od_a: assert property (clkEn && mode[3] == MMIO_M_ODFLT |=>
        pinOe[3] == $past(faultIn.anyFault) && !pinOut[3])
        else $error("open-drain any-fault output wrong");
    selb_fault_a: assert property (clkEn && mode[5] == MMIO_M_PPFLT && faultB |=> pinOe[5] && !pinOut[5])
        else $error("selectable fault b not low");

    // input functions
    margin_up_a: assert property (clkEn && mode[1] == MMIO_M_SPEC |=>
        funcOut.marginRaise == $past(sync2_r[1]))
        else $error("margin raise input wrong");
    mr_pass_a: assert property (clkEn && mode[3] == MMIO_M_SPEC |=>
        funcOut.manualReset == $past(sync2_r[3]))
        else $error("manual reset input wrong");
    mdis_off_a: assert property (clkEn && mode[5] != MMIO_M_SENSE |=> !funcOut.marginDisable)
        else $error("margin disable outside its mode");
    sense_pass_a: assert property (clkEn |=> funcOut.senseIn == $past(sync2_r[3:0]))
        else $error("sense level not passed on");
    discharge_out_a: assert property (clkEn |=> senseDischarge == $past(pdn_r[MMIO_PDN_LSB +: 4]))
        else $error("discharge enables wrong");

    // register side and clock enable
    data_mask_a: assert property (outLvl_r[7:6] == 2'h0)
        else $error("unused output bits set");
    rd_out_a: assert property (clkEn && regReq.rdEn && regReq.addr == MMIO_OFS_OUT |=>
        regRdata == $past(outLvl_r))
        else $error("output register read wrong");
    rvalid_pulse_a: assert property (clkEn && !regReq.rdEn |=> !regRvalid)
        else $error("read valid without request");
    freeze_hold_a: assert property (!clkEn |=>
        $stable(outLvl_r) && $stable(pinOe) && $stable(regRvalid))
        else $error("state moved with clock enable low");

    pp_cov_c: cover property (clkEn && mode[0] == MMIO_M_PPIO ##1 pinOut[0]);
    od_cov_c: cover property (clkEn && mode[5] == MMIO_M_SPEC && faultIn.seqFault ##1 pinOe[5]);
    rd_cov_c: cover property (regRvalid);
    mr_cov_c: cover property (funcOut.manualReset);
    flt_cov_c: cover property (clkEn && mode[3] == MMIO_M_PPFLT ##1 !pinOut[3]);
endmodule
`default_nettype wire

/* File: tb/mmio_board_model.sv */
// board model: pull-ups and external drivers on the six pads
`timescale 1ns/100ps
`default_nettype none
module mmio_board_model (
    input  wire logic [5:0] pinOut,   // level offered by the block
    input  wire logic [5:0] pinOe,    // block drives the pad when high
    input  wire logic [5:0] extDrive, // board drives the pad when high
    input  wire logic [5:0] extLevel, // level the board drives
    output logic      [5:0] pinIn     // resolved pad level
);
    ////////////////////////////////////////////////////////////////
    // resolve each pad: block first, then board, else pull-up
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (pinOe[i]) begin
                pinIn[i] = pinOut[i];   // block drives
            end else if (extDrive[i]) begin
                pinIn[i] = extLevel[i]; // board drives
            end else begin
                pinIn[i] = 1'b1;        // released pad rests high
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// testbench: register access, pin modes, fault outputs and pad levels
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if (16'(got) !== 16'(exp)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 16'(got), 16'(exp)); end end
module testbench
    import mmio_pkg::*;
;
    logic        clk;            // 50 MHz clock
    logic        rst_n;          // async reset, active low
    logic        clkEn;          // clock enable to the block
    mmio_req_t   regReq;         // register request
    logic [7:0]  regRdata;       // read data
    logic        regRvalid;      // read data valid
    mmio_fault_t faultIn;        // fault sources
    logic [5:0]  pinIn;          // resolved pads
    logic [5:0]  pinOut;         // pad level from block
    logic [5:0]  pinOe;          // pad enable from block
    logic [5:0]  extDrive;       // board drive enables
    logic [5:0]  extLevel;       // board levels
    logic [3:0]  senseDischarge; // pulldown enables
    mmio_func_t  funcOut;        // decoded functions
    logic [7:0]  rv;             // last read value
    int          num_errors;     // mismatches
    int          tests_run;      // comparisons

    mmio_pin_bank #(.NPINS(6)) dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regReq(regReq),
        .regRdata(regRdata), .regRvalid(regRvalid), .faultIn(faultIn), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .senseDischarge(senseDischarge), .funcOut(funcOut));
    mmio_board_model board (.pinOut(pinOut), .pinOe(pinOe), .extDrive(extDrive),
        .extLevel(extLevel), .pinIn(pinIn));

    ////////////////////////////////////////////////////////////////
    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    // helpers: waits, register cycles, verdict
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic give_verdict;
        $display("comparisons=%0d mismatches=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regReq.wrEn = 1'b1;
        regReq.addr = a;
        regReq.wdata = d;
        @(negedge clk);
        regReq.wrEn = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int i;
        regReq.rdEn = 1'b1;
        regReq.addr = a;
        @(negedge clk);
        regReq.rdEn = 1'b0;
        for (i = 0; i < 4 && regRvalid !== 1'b1; i++) @(negedge clk);
        if (i == 4) begin
            num_errors++;
            give_verdict();
        end
        d = regRdata;
        @(negedge clk);
    endtask
    // only documented mode codes are ever written
    task automatic modes(input logic [7:0] l, input logic [7:0] m, input logic [7:0] h);
        wr(MMIO_OFS_MODEL, l);
        wr(MMIO_OFS_MODEM, m);
        wr(MMIO_OFS_MODEH, h);
        cyc(3);
    endtask

    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        rd(MMIO_OFS_OUT, rv);
        `CHK(rv, 8'h00)
        `CHK(regRvalid, 1'b0)
        rd(MMIO_OFS_MODEM, rv);
        `CHK(rv, 8'h00)
        rd(MMIO_OFS_IN, rv);
        `CHK(rv, 8'h3F)
        `CHK(pinOe, 6'h00)
        $display("done: reset");
    endtask
    task automatic t_sense;
        extDrive = 6'h3F;
        extLevel = 6'h25;
        cyc(5);
        `CHK({funcOut.senseValid, funcOut.senseIn}, 8'hF5)
        `CHK(funcOut.marginDisable, 1'b1)
        wr(MMIO_OFS_PDN, 8'hFF);
        rd(MMIO_OFS_PDN, rv);
        `CHK(rv, 8'hF0)
        `CHK(senseDischarge, 4'hF)
        wr(MMIO_OFS_PDN, 8'h00);
        extDrive = 6'h00;
        $display("done: sense");
    endtask
    task automatic t_pushpull;
        modes(8'h49, 8'h92, 8'h00);
        wr(MMIO_OFS_OUT, 8'hFF);
        rd(MMIO_OFS_OUT, rv);
        `CHK(rv, 8'h3F)
        wr(MMIO_OFS_OUT, 8'h2A);
        cyc(2);
        `CHK({pinOe, pinOut}, 12'hFEA)
        wr(MMIO_OFS_IN, 8'h00);
        rd(MMIO_OFS_IN, rv);
        `CHK(rv, 8'h2A)
        wr(MMIO_OFS_MODEH, 8'hFC);
        rd(MMIO_OFS_MODEH, rv);
        `CHK(rv, 8'h00)
        rd(8'h30, rv);
        `CHK(rv, 8'h00)
        $display("done: push-pull");
    endtask
    task automatic t_opendrain;
        modes(8'h92, 8'h24, 8'h01);
        wr(MMIO_OFS_OUT, 8'h0F);
        cyc(2);
        `CHK({pinOe, pinOut}, 12'hC00)
        rd(MMIO_OFS_IN, rv);
        `CHK(rv, 8'h0F)
        $display("done: open-drain");
    endtask
    task automatic t_mixed;
        wr(MMIO_OFS_OUT, 8'h00);
        modes(8'h51, 8'hC7, 8'h00);
        `CHK({pinOe, pinOut}, 12'hAC8)
        $display("done: mixed modes");
    endtask
    task automatic t_fault;
        modes(8'hDB, 8'hB6, 8'h01);
        faultIn.anyFault = 1'b1;
        faultIn.monFault = 12'h001;
        faultIn.selA = 12'h001;
        faultIn.selB = 12'h002;
        cyc(3);
        `CHK({pinOe, pinOut}, 12'hFE0)
        faultIn.anyFault = 1'b0;
        faultIn.selB = 12'h003;
        cyc(3);
        `CHK(pinOut, 6'h0F)
        modes(8'h24, 8'h49, 8'h02);
        faultIn.anyFault = 1'b1;
        cyc(3);
        `CHK({pinOe, pinOut}, 12'hFC0)
        faultIn = '0;
        cyc(3);
        `CHK(pinOe, 6'h00)
        $display("done: faults");
    endtask
    task automatic t_special;
        modes(8'h6D, 8'hDB, 8'h02);
        extDrive = 6'h3F;
        extLevel = 6'h15;
        cyc(4);
        `CHK(pinOe, 6'h00)
        rd(MMIO_OFS_IN, rv);
        `CHK(rv, 8'h15)
        modes(8'hFD, 8'hFF, 8'h03);
        extDrive = 6'h1F;
        extLevel = 6'h0A;
        faultIn.seqFault = 1'b1;
        cyc(4);
        `CHK({funcOut.marginRaise, funcOut.marginLower, funcOut.manualReset, funcOut.watchdogKick}, 4'hA)
        `CHK({pinOe[5], pinOut[5]}, 2'b10)
        faultIn.seqFault = 1'b0;
        cyc(3);
        `CHK(pinOe[5], 1'b0)
        wr(MMIO_OFS_MODEM, 8'h7F);
        faultIn.watchdogExpire = 1'b1;
        cyc(3);
        `CHK({pinOe[5], pinOut[5]}, 2'b10)
        faultIn.watchdogExpire = 1'b0;
        cyc(3);
        `CHK(pinOe[5], 1'b0)
        $display("done: special functions");
    endtask
    task automatic t_freeze;
        clkEn = 1'b0;
        faultIn.watchdogExpire = 1'b1;
        wr(MMIO_OFS_OUT, 8'h15);
        cyc(2);
        `CHK(pinOe, 6'h00)
        clkEn = 1'b1;
        rd(MMIO_OFS_OUT, rv);
        `CHK({rv, pinOe}, 14'h0020)
        faultIn.watchdogExpire = 1'b0;
        cyc(2);
        $display("done: clock enable");
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        num_errors = 0;
        tests_run = 0;
        regReq = '0;
        faultIn = '0;
        extDrive = 6'h00;
        extLevel = 6'h00;
        clkEn = 1'b1;
        rst_n = 1'b0;
        cyc(5);
        rst_n = 1'b1;
        cyc(1);
        t_reset();
        t_sense();
        t_pushpull();
        t_opendrain();
        t_mixed();
        t_fault();
        t_special();
        t_freeze();
        give_verdict();
    end
endmodule
`default_nettype wire
